// [inc/uart_cfg.svh]
// Purpose: offsets, reset values, divisors and counts of the uart
// Assumes: word-wide wishbone registers, index times four is byte address
// Notes: register indices, reset values, divisors and timing counts live here as macros
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define IDX_CTRL_ONE 12'hFE5
`define IDX_CTRL_TWO 12'hFE6
`define IDX_STATUS 12'hFE7
`define IDX_TX_BUF 12'hFE8
`define IDX_RX_BUF 12'hFE9
`define IDX_TMR_CMP 12'hFEA

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_CTRL_ONE 8'h00
`define RST_CTRL_TWO 8'h00
`define RST_TMR_CMP 8'h01
`define RST_STATUS 8'h0C

// ----------------------------------------------------------------------
// base clock divisors, one per fixed baud source code; code 6 takes the timer compare, DIV_TMR_ZERO when it is zero
// ----------------------------------------------------------------------
`define DIV_CODE0 9'h00D
`define DIV_CODE1 9'h01A
`define DIV_CODE2 9'h034
`define DIV_CODE3 9'h068
`define DIV_CODE4 9'h0D0
`define DIV_CODE5 9'h1A0
`define DIV_CODE7 9'h060
`define DIV_TMR_ZERO 9'h100
`define BAUD_SEL_TIMER 3'h6

// ----------------------------------------------------------------------
// bit timing in sample ticks, and the index of the last data bit
// ----------------------------------------------------------------------
`define TICK_LAST 4'hF
`define TICK_SAMPLE_A 4'h7
`define TICK_SAMPLE_B 4'h8
`define TICK_SAMPLE_C 4'h9
`define DATA_LAST 3'h7

// ----------------------------------------------------------------------
// noise filter acceptance times in system clock periods
// ----------------------------------------------------------------------
`define FILT_CNT_1 7'h1F
`define FILT_CNT_2 7'h3F
`define FILT_CNT_3 7'h7F

`endif

// [inc/uart_pkg.sv]
// Purpose: shared types of the asynchronous serial port
// Assumes: bit layouts fixed by the control and status bytes
// Notes: numbers sit in uart_cfg.svh, this file holds only types
package uart_pkg;

	// control byte one: enables, format and baud source
	typedef struct packed {
		logic transmit_enable_bit;
		logic receive_enable_bit;
		logic tx_stop_length;
		logic parity_even;
		logic parity_add_bit;
		logic [2:0] baud_source_select;
	} ctrl_one_t;

	// control byte two: receive filter and stop length
	typedef struct packed {
		logic [2:0] unused_hi;
		logic [1:0] rx_noise_filter_select;
		logic rx_stop_length;
		logic [1:0] unused_lo;
	} ctrl_two_t;

	// status byte as software reads it
	typedef struct packed {
		logic parity_error_flag;
		logic framing_error_flag;
		logic overrun_error_flag;
		logic rx_full_flag;
		logic tx_done_flag;
		logic tx_buffer_empty_flag;
		logic [1:0] unused;
	} status_t;

	// frame position, gray coded along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_DATA = 3'h3,
		ST_PARITY = 3'h2,
		ST_STOP1 = 3'h6,
		ST_STOP2 = 3'h7
	} frame_state_t;

endpackage

// [core/async_serial_uart.sv]
// Purpose: full-duplex asynchronous serial port behind a wishbone slave
// Assumes: one clock clk_i at 40 MHz, classic wishbone, 8-bit data frames
// Notes: status read arms the buffer accesses that clear flags
`timescale 1ns/1ps
`include "uart_cfg.svh"

module async_serial_uart #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// serial line
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	// events
	output logic tx_interrupt_o,
	output logic rx_interrupt_o
);
	import uart_pkg::*;

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	if (ADDR_W < 14)
	begin : g_chk
		$error("ADDR_W too small for the register map");
	end

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	ctrl_one_t ctrl1_ff, nxt_ctrl1;
	ctrl_two_t ctrl2_ff, nxt_ctrl2;
	logic [7:0] tmr_cmp_ff, nxt_tmr_cmp;
	status_t stat_ff, nxt_stat;
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic tx_arm_ff, nxt_tx_arm;
	logic rx_arm_ff, nxt_rx_arm;
	logic [3:0] snap_ff, nxt_snap;
	logic [7:0] tx_buf_ff, nxt_tx_buf;
	logic [7:0] rx_buf_ff, nxt_rx_buf;
	logic [8:0] pre_ff, nxt_pre;
	logic [2:0] sync_ff, nxt_sync;
	logic stable_ff, nxt_stable;
	logic line_ff, nxt_line;
	logic [6:0] filt_ff, nxt_filt;
	frame_state_t tx_st_ff, nxt_tx_st;
	logic [3:0] tx_rt_ff, nxt_tx_rt;
	logic [2:0] tx_idx_ff, nxt_tx_idx;
	logic [7:0] tx_sh_ff, nxt_tx_sh;
	logic tx_out_ff, nxt_tx_out;
	logic tx_int_ff, nxt_tx_int;
	frame_state_t rx_st_ff, nxt_rx_st;
	logic [3:0] rx_rt_ff, nxt_rx_rt;
	logic [2:0] rx_idx_ff, nxt_rx_idx;
	logic [7:0] rx_sh_ff, nxt_rx_sh;
	logic [2:0] rx_smp_ff, nxt_rx_smp;
	logic rx_parity_error_flag_ff, nxt_rx_parity_error_flag;
	logic rx_framing_error_flag_ff, nxt_rx_framing_error_flag;
	logic rx_int_ff, nxt_rx_int;

	// ------------------------------------------------------------------
	// combinational helpers
	// ------------------------------------------------------------------
	logic req;
	logic [11:0] idx;
	logic [8:0] divisor;
	logic tick;
	logic bit_val;
	logic [6:0] filt_lim;

	assign req = cyc_i & stb_i & ~ack_ff;
	assign idx = adr_i[13:2];
	assign ack_o = ack_ff;
	assign dat_o = rdata_ff;
	assign serial_out_pin_o = tx_out_ff;
	assign tx_interrupt_o = tx_int_ff;
	assign rx_interrupt_o = rx_int_ff;

	// majority of the three samples taken in the bit
	assign bit_val = (rx_smp_ff[0] & rx_smp_ff[1])
		| (rx_smp_ff[1] & rx_smp_ff[2])
		| (rx_smp_ff[0] & rx_smp_ff[2]);

	// base clock divisor, shared by both directions
	always_comb
	begin
		unique case (ctrl1_ff.baud_source_select)
			3'h0: divisor = `DIV_CODE0;
			3'h1: divisor = `DIV_CODE1;
			3'h2: divisor = `DIV_CODE2;
			3'h3: divisor = `DIV_CODE3;
			3'h4: divisor = `DIV_CODE4;
			3'h5: divisor = `DIV_CODE5;
			3'h6: divisor = (tmr_cmp_ff == 8'h00) ? `DIV_TMR_ZERO
				: {1'b0, tmr_cmp_ff};
			3'h7: divisor = `DIV_CODE7;
		endcase
	end
	assign tick = (pre_ff >= divisor - 9'h001);

	// filter acceptance time per setting
	always_comb
	begin
		unique case (ctrl2_ff.rx_noise_filter_select)
			2'h1: filt_lim = `FILT_CNT_1;
			2'h2: filt_lim = `FILT_CNT_2;
			2'h3: filt_lim = `FILT_CNT_3;
			default: filt_lim = 7'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// input synchroniser, noise filter and prescaler
	// ------------------------------------------------------------------
	// third-stage agreement keeps metastable samples out of the filter
	always_comb
	begin
		nxt_sync = {sync_ff[1:0], serial_in_pin_i};
		nxt_stable = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : stable_ff;
		nxt_line = line_ff;
		nxt_filt = 7'h00;
		if (ctrl2_ff.rx_noise_filter_select == 2'h0)
		begin
			nxt_line = stable_ff;
		end
		else if (stable_ff != line_ff)
		begin
			// a level must hold filt_lim clocks before it counts
			if (filt_ff >= filt_lim - 7'h01)
			begin
				nxt_line = stable_ff;
			end
			else
			begin
				nxt_filt = filt_ff + 7'h01;
			end
		end
		nxt_pre = tick ? 9'h000 : pre_ff + 9'h001;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync_ff <= 3'h7;
			stable_ff <= 1'b1;
			line_ff <= 1'b1;
			filt_ff <= 7'h00;
			pre_ff <= 9'h000;
		end
		else
		begin
			sync_ff <= nxt_sync;
			stable_ff <= nxt_stable;
			line_ff <= nxt_line;
			filt_ff <= nxt_filt;
			pre_ff <= nxt_pre;
		end
	end

	// ------------------------------------------------------------------
	// bus, flags, transmitter and receiver
	// ------------------------------------------------------------------
	// one process because the flags have setters on both sides
	always_comb
	begin
		nxt_ctrl1 = ctrl1_ff;
		nxt_ctrl2 = ctrl2_ff;
		nxt_tmr_cmp = tmr_cmp_ff;
		nxt_stat = stat_ff;
		nxt_ack = req;
		nxt_rdata = rdata_ff;
		nxt_tx_arm = tx_arm_ff;
		nxt_rx_arm = rx_arm_ff;
		nxt_snap = snap_ff;
		nxt_tx_buf = tx_buf_ff;
		nxt_rx_buf = rx_buf_ff;
		nxt_tx_st = tx_st_ff;
		nxt_tx_rt = tx_rt_ff;
		nxt_tx_idx = tx_idx_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_tx_out = tx_out_ff;
		nxt_tx_int = 1'b0;
		nxt_rx_st = rx_st_ff;
		nxt_rx_rt = rx_rt_ff;
		nxt_rx_idx = rx_idx_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_rx_smp = rx_smp_ff;
		nxt_rx_parity_error_flag = rx_parity_error_flag_ff;
		nxt_rx_framing_error_flag = rx_framing_error_flag_ff;
		nxt_rx_int = 1'b0;

		// bus access: clears first, hardware sets below win
		if (req)
		begin
			nxt_rdata = 32'h0000_0000;
			if (we_i && sel_i[0])
			begin
				unique case (idx)
					`IDX_CTRL_ONE: nxt_ctrl1 = ctrl_one_t'(dat_i[7:0]);
					`IDX_CTRL_TWO: nxt_ctrl2 = ctrl_two_t'(dat_i[7:0]);
					`IDX_TMR_CMP: nxt_tmr_cmp = dat_i[7:0];
					`IDX_TX_BUF:
					begin
						// without the status read the write is lost
						if (tx_arm_ff)
						begin
							nxt_tx_buf = dat_i[7:0];
							nxt_stat.tx_buffer_empty_flag = 1'b0;
							nxt_tx_arm = 1'b0;
						end
					end
					default: ;
				endcase
			end
			else if (!we_i)
			begin
				unique case (idx)
					`IDX_STATUS:
					begin
						nxt_rdata = {24'h00_0000, stat_ff};
						nxt_tx_arm = 1'b1;
						nxt_rx_arm = 1'b1;
						// only flags seen now may be cleared later
						nxt_snap = stat_ff[7:4];
					end
					`IDX_RX_BUF:
					begin
						nxt_rdata = {24'h00_0000, rx_buf_ff};
						if (rx_arm_ff)
						begin
							nxt_rx_arm = 1'b0;
							nxt_stat[7:4] = stat_ff[7:4] & ~snap_ff;
						end
					end
					`IDX_TMR_CMP: nxt_rdata = {24'h00_0000, tmr_cmp_ff};
					default: ;
				endcase
			end
		end

		// transmitter, advancing on base ticks only
		if (tick)
		begin
			unique case (tx_st_ff)
				ST_IDLE:
				begin
					nxt_tx_out = 1'b1;
					if (ctrl1_ff.transmit_enable_bit
						&& !stat_ff.tx_buffer_empty_flag)
					begin
						nxt_tx_sh = tx_buf_ff;
						nxt_stat.tx_buffer_empty_flag = 1'b1;
						nxt_stat.tx_done_flag = 1'b0;
						nxt_tx_int = 1'b1;
						nxt_tx_out = 1'b0;
						nxt_tx_rt = 4'h0;
						nxt_tx_idx = 3'h0;
						nxt_tx_st = ST_START;
					end
					else if (!ctrl1_ff.transmit_enable_bit)
					begin
						// a byte left behind by a disable is never sent
						nxt_stat.tx_buffer_empty_flag = 1'b1;
					end
				end
				default:
				begin
					nxt_tx_rt = tx_rt_ff + 4'h1;
					if (tx_rt_ff == `TICK_LAST)
					begin
						unique case (tx_st_ff)
							ST_START:
							begin
								nxt_tx_out = tx_sh_ff[0];
								nxt_tx_st = ST_DATA;
							end
							ST_DATA:
							begin
								nxt_tx_idx = tx_idx_ff + 3'h1;
								if (tx_idx_ff == `DATA_LAST)
								begin
									if (ctrl1_ff.parity_add_bit)
									begin
										nxt_tx_out = ^tx_sh_ff
											^ ~ctrl1_ff.parity_even;
										nxt_tx_st = ST_PARITY;
									end
									else
									begin
										nxt_tx_out = 1'b1;
										nxt_tx_st = ST_STOP1;
									end
								end
								else
								begin
									nxt_tx_out = tx_sh_ff[tx_idx_ff + 3'h1];
								end
							end
							ST_PARITY:
							begin
								nxt_tx_out = 1'b1;
								nxt_tx_st = ST_STOP1;
							end
							ST_STOP1:
							begin
								if (ctrl1_ff.tx_stop_length)
								begin
									nxt_tx_st = ST_STOP2;
								end
								else
								begin
									nxt_tx_st = ST_IDLE;
								end
							end
							ST_STOP2: nxt_tx_st = ST_IDLE;
							default: nxt_tx_st = ST_IDLE;
						endcase
						// frame over with nothing waiting
						if ((tx_st_ff == ST_STOP2 || (tx_st_ff == ST_STOP1
							&& !ctrl1_ff.tx_stop_length))
							&& stat_ff.tx_buffer_empty_flag)
						begin
							nxt_stat.tx_done_flag = 1'b1;
						end
					end
				end
			endcase
		end

		// receiver, halted between frames by disable or overrun
		if (tick)
		begin
			if (rx_st_ff == ST_IDLE)
			begin
				if (ctrl1_ff.receive_enable_bit
					&& !stat_ff.overrun_error_flag
					&& !line_ff)
				begin
					nxt_rx_st = ST_START;
					nxt_rx_rt = 4'h1;
					nxt_rx_idx = 3'h0;
					nxt_rx_parity_error_flag = 1'b0;
					nxt_rx_framing_error_flag = 1'b0;
				end
			end
			else
			begin
				nxt_rx_rt = rx_rt_ff + 4'h1;
				unique case (rx_rt_ff)
					`TICK_SAMPLE_A: nxt_rx_smp[0] = line_ff;
					`TICK_SAMPLE_B: nxt_rx_smp[1] = line_ff;
					`TICK_SAMPLE_C: nxt_rx_smp[2] = line_ff;
					default: ;
				endcase
				if (rx_rt_ff == `TICK_LAST)
				begin
					unique case (rx_st_ff)
						// a high start is a glitch, go back hunting
						ST_START: nxt_rx_st = bit_val ? ST_IDLE : ST_DATA;
						ST_DATA:
						begin
							nxt_rx_sh = {bit_val, rx_sh_ff[7:1]};
							nxt_rx_idx = rx_idx_ff + 3'h1;
							if (rx_idx_ff == `DATA_LAST)
							begin
								nxt_rx_st = ctrl1_ff.parity_add_bit
									? ST_PARITY : ST_STOP1;
							end
						end
						ST_PARITY:
						begin
							nxt_rx_parity_error_flag = (^rx_sh_ff ^ ~ctrl1_ff.parity_even)
								!= bit_val;
							nxt_rx_st = ST_STOP1;
						end
						ST_STOP1, ST_STOP2:
						begin
							nxt_rx_framing_error_flag = rx_framing_error_flag_ff | ~bit_val;
							if (rx_st_ff == ST_STOP1
								&& ctrl2_ff.rx_stop_length)
							begin
								nxt_rx_st = ST_STOP2;
							end
							else
							begin
								nxt_rx_st = ST_IDLE;
								if (stat_ff.rx_full_flag)
								begin
									// old byte stays, new one dropped
									nxt_stat.overrun_error_flag = 1'b1;
								end
								else
								begin
									nxt_rx_buf = rx_sh_ff;
									nxt_stat.rx_full_flag = 1'b1;
									nxt_stat.parity_error_flag = rx_parity_error_flag_ff;
									nxt_stat.framing_error_flag = rx_framing_error_flag_ff
										| ~bit_val;
									nxt_rx_int = 1'b1;
								end
							end
						end
						default: nxt_rx_st = ST_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl1_ff <= ctrl_one_t'(`RST_CTRL_ONE);
			ctrl2_ff <= ctrl_two_t'(`RST_CTRL_TWO);
			tmr_cmp_ff <= `RST_TMR_CMP;
			stat_ff <= status_t'(`RST_STATUS);
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			tx_arm_ff <= 1'b0;
			rx_arm_ff <= 1'b0;
			snap_ff <= 4'h0;
			tx_buf_ff <= 8'h00;
			rx_buf_ff <= 8'h00;
			tx_st_ff <= ST_IDLE;
			tx_rt_ff <= 4'h0;
			tx_idx_ff <= 3'h0;
			tx_sh_ff <= 8'h00;
			tx_out_ff <= 1'b1;
			tx_int_ff <= 1'b0;
			rx_st_ff <= ST_IDLE;
			rx_rt_ff <= 4'h0;
			rx_idx_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_smp_ff <= 3'h7;
			rx_parity_error_flag_ff <= 1'b0;
			rx_framing_error_flag_ff <= 1'b0;
			rx_int_ff <= 1'b0;
		end
		else
		begin
			ctrl1_ff <= nxt_ctrl1;
			ctrl2_ff <= nxt_ctrl2;
			tmr_cmp_ff <= nxt_tmr_cmp;
			stat_ff <= nxt_stat;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			tx_arm_ff <= nxt_tx_arm;
			rx_arm_ff <= nxt_rx_arm;
			snap_ff <= nxt_snap;
			tx_buf_ff <= nxt_tx_buf;
			rx_buf_ff <= nxt_rx_buf;
			tx_st_ff <= nxt_tx_st;
			tx_rt_ff <= nxt_tx_rt;
			tx_idx_ff <= nxt_tx_idx;
			tx_sh_ff <= nxt_tx_sh;
			tx_out_ff <= nxt_tx_out;
			tx_int_ff <= nxt_tx_int;
			rx_st_ff <= nxt_rx_st;
			rx_rt_ff <= nxt_rx_rt;
			rx_idx_ff <= nxt_rx_idx;
			rx_sh_ff <= nxt_rx_sh;
			rx_smp_ff <= nxt_rx_smp;
			rx_parity_error_flag_ff <= nxt_rx_parity_error_flag;
			rx_framing_error_flag_ff <= nxt_rx_framing_error_flag;
			rx_int_ff <= nxt_rx_int;
		end
	end

endmodule

// [test/uart_props.sv]
// Purpose: port-level checks of the asynchronous serial port
// Assumes: one clock, synchronous active high reset
// Notes: bound to every instance of the design
`timescale 1ns/1ps
module uart_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic [31:0] dat_o,
	// line and events
	input wire logic serial_out_pin_o,
	input wire logic tx_interrupt_o,
	input wire logic rx_interrupt_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// a new request (one cycle) and a frame start (eight low cycles), as sequences
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_start_bit;
		!serial_out_pin_o [*8];
	endsequence
	property p_ack_next;
		s_req |=> ack_o;
	endproperty
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	property p_ack_cause;
		ack_o |-> $past(cyc_i && stb_i);
	endproperty
	property p_read_upper;
		ack_o |-> dat_o[31:8] == 24'h000000;
	endproperty
	property p_tx_start;
		tx_interrupt_o |-> s_start_bit;
	endproperty
	property p_tx_gap;
		tx_interrupt_o |=> !tx_interrupt_o [*8];
	endproperty
	property p_rx_gap;
		rx_interrupt_o |=> !rx_interrupt_o [*8];
	endproperty
	// reset itself is the cause here, so no disable
	property p_reset_idle;
		disable iff (1'b0)
		$fell(rst_i) |-> serial_out_pin_o && !ack_o && !tx_interrupt_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("ack missing one cycle after request");
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	a_read_upper: assert property (p_read_upper)
		else $error("read data upper bits not zero");
	a_tx_start: assert property (p_tx_start)
		else $error("frame start without low start bit");
	a_tx_gap: assert property (p_tx_gap)
		else $error("tx event repeated inside a bit");
	a_rx_gap: assert property (p_rx_gap)
		else $error("rx event repeated inside a bit");
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");
endmodule

bind async_serial_uart uart_props chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
	.serial_out_pin_o(serial_out_pin_o), .tx_interrupt_o(tx_interrupt_o),
	.rx_interrupt_o(rx_interrupt_o));

// [test/uart_peer.sv]
// Purpose: remote serial peer on the line of the port
// Assumes: bit time in system clocks set by the bench
// Notes: idles high between frames; samples mid bit
`timescale 1ns/1ps
module uart_peer (
	// clock
	input wire logic clk_i,
	// line toward the port and back
	output logic line_o,
	input wire logic line_i
);
	int bit_clks = 208;
	initial line_o = 1'b1;
	// one bit held for a full bit time
	task automatic drive(input logic b);
		line_o <= b;
		repeat (bit_clks) @(posedge clk_i);
	endtask
	// frame out lsb first; bad flips parity, stp gives stop levels
	task automatic send(input logic [7:0] d, input logic even,
		input logic bad, input logic [1:0] stp, input int nstop);
		@(posedge clk_i);
		drive(1'b0);
		for (int i = 0; i < 8; i++)
			drive(d[i]);
		drive((even ? ^d : ~^d) ^ bad);
		for (int i = 0; i < nstop; i++)
			drive(stp[i]);
		line_o <= 1'b1;
	endtask
	// short low pulse, for the noise filter
	task automatic glitch(input int n);
		@(posedge clk_i);
		line_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		line_o <= 1'b1;
	endtask
	// frame in; ok low if no start seen or start too short
	task automatic recv(input logic par, output logic [7:0] d,
		output logic p, output logic [1:0] s, output logic ok);
		int n;
		n = 0;
		while (line_i !== 1'b0 && n < 5000)
		begin
			@(posedge clk_i);
			n++;
		end
		ok = n < 5000;
		repeat (bit_clks / 2) @(posedge clk_i);
		ok = ok && line_i === 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			repeat (bit_clks) @(posedge clk_i);
			d[i] = line_i;
		end
		p = 1'b0;
		if (par)
		begin
			repeat (bit_clks) @(posedge clk_i);
			p = line_i;
		end
		for (int i = 0; i < 2; i++)
		begin
			repeat (bit_clks) @(posedge clk_i);
			s[i] = line_i;
		end
		repeat (bit_clks) @(posedge clk_i);
	endtask
endmodule

// [test/async_serial_uart_test.sv]
// Purpose: self-checking bench of the asynchronous serial port
// Assumes: 40 MHz clock, peer model on the serial line
// Notes: expectations come from status layout and frame format
`timescale 1ns/1ps
module async_serial_uart_test;
	import uart_pkg::*;
	// ----
	// signals
	// ----
	localparam logic [15:0] A_C1 = 16'h3F94;
	localparam logic [15:0] A_C2 = 16'h3F98;
	localparam logic [15:0] A_ST = 16'h3F9C;
	localparam logic [15:0] A_TX = 16'h3FA0;
	localparam logic [15:0] A_RX = 16'h3FA4;
	localparam logic [15:0] A_TM = 16'h3FA8;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic rx_line, tx_line, tx_int, rx_int;
	logic [15:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	int n_errors = 0;
	int total_checks = 0;
	int rx_cnt = 0;
	async_serial_uart dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.serial_in_pin_i(rx_line), .serial_out_pin_o(tx_line),
		.tx_interrupt_o(tx_int), .rx_interrupt_o(rx_int));
	uart_peer peer_u (.clk_i(clk_i), .line_o(rx_line), .line_i(tx_line));
	// ----
	// helpers
	// ----
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// classic cycle: hold until ack is sampled, then release
	task automatic wb(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= {24'h000000, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20)
			chk("ack timeout", 32'h0, 32'h1);
		if (n >= 20)
			tally_and_finish();
	endtask
	task automatic put(input logic [15:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic get(input logic [15:0] a, input logic [31:0] e,
		input string what);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(what, q, e);
	endtask
	// frame in at even parity, then sync and tick slack to settle
	task automatic rx_frame(input logic [7:0] d, input logic bad,
		input logic [1:0] stp, input int nstop);
		peer_u.send(d, 1'b1, bad, stp, nstop);
		repeat (60) @(posedge clk_i);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_unarmed();
		logic lo;
		lo = 1'b0;
		put(A_C1, 8'h80);
		put(A_TX, 8'h55);
		repeat (300) @(posedge clk_i) lo = lo | ~tx_line;
		chk("line held high", lo, 1'b0);
		get(A_ST, 32'h0C, "status unarmed");
		$display("test unarmed done");
	endtask
	task automatic t_reset();
		get(A_ST, 32'h0C, "status reset");
		get(A_C1, 32'h0, "control write only");
		get(A_TM, 32'h1, "compare reset");
		get(16'h3FB0, 32'h0, "unmapped");
		$display("test reset done");
	endtask
	task automatic t_tx(input logic [2:0] code, input int div,
		input logic [7:0] tm, input logic par, input logic even,
		input logic st2, input logic [7:0] d);
		logic [7:0] rd;
		logic rp, ok;
		logic [1:0] rs;
		int n;
		n = 0;
		put(A_C1, 8'h00);
		put(A_TM, tm);
		put(A_C1, {1'b1, 1'b0, st2, even, par, code});
		peer_u.bit_clks = 16 * div;
		fork
			peer_u.recv(par, rd, rp, rs, ok);
			begin
				get(A_ST, 32'h0C, "status before");
				put(A_TX, d);
				while (tx_int !== 1'b1 && n < 3000)
				begin
					@(posedge clk_i);
					n++;
				end
				chk("tx event", n < 3000, 1'b1);
				if (n >= 3000)
					tally_and_finish();
				get(A_ST, 32'h04, "status sending");
			end
		join
		chk("frame seen", ok, 1'b1);
		if (!ok)
			tally_and_finish();
		chk("tx data", rd, d);
		if (par)
			chk("tx parity", rp, even ? ^d : ~^d);
		chk("tx stop", rs, 2'b11);
		get(A_ST, 32'h0C, "status end");
		$display("test tx done");
	endtask
	task automatic t_rx();
		int c;
		put(A_C1, 8'h00);
		put(A_C2, 8'h00);
		put(A_C1, 8'h58);
		peer_u.bit_clks = 208;
		c = rx_cnt;
		rx_frame(8'h3C, 1'b0, 2'b11, 1);
		chk("rx event", rx_cnt - c, 1);
		get(A_ST, 32'h1C, "rx full");
		get(A_RX, 32'h3C, "rx data");
		get(A_ST, 32'h0C, "rx cleared");
		rx_frame(8'h3C, 1'b1, 2'b11, 1);
		get(A_ST, 32'h9C, "parity error");
		get(A_RX, 32'h3C, "rx data parity");
		get(A_ST, 32'h0C, "parity cleared");
		rx_frame(8'h5A, 1'b0, 2'b00, 1);
		get(A_ST, 32'h5C, "framing error");
		get(A_RX, 32'h5A, "rx data framing");
		get(A_ST, 32'h0C, "framing cleared");
		rx_frame(8'h11, 1'b0, 2'b11, 1);
		rx_frame(8'h22, 1'b0, 2'b11, 1);
		get(A_ST, 32'h3C, "overrun");
		get(A_RX, 32'h11, "rx data kept");
		get(A_ST, 32'h0C, "overrun cleared");
		// overrun raised after the status read outlives the buffer read
		rx_frame(8'h44, 1'b0, 2'b11, 1);
		get(A_ST, 32'h1C, "full before late");
		rx_frame(8'h77, 1'b0, 2'b11, 1);
		get(A_RX, 32'h44, "rx data late");
		get(A_ST, 32'h2C, "late overrun");
		// buffer now empty, so only the overrun can block this frame
		c = rx_cnt;
		rx_frame(8'h99, 1'b0, 2'b11, 1);
		chk("rx halted", rx_cnt - c, 0);
		get(A_RX, 32'h44, "rx data halted");
		get(A_ST, 32'h0C, "late cleared");
		put(A_C2, 8'h04);
		rx_frame(8'h66, 1'b0, 2'b01, 2);
		get(A_ST, 32'h5C, "second stop");
		get(A_RX, 32'h66, "rx data two stop");
		$display("test rx done");
	endtask
	task automatic t_filter();
		int c;
		c = rx_cnt;
		put(A_C2, 8'h18);
		peer_u.glitch(120);
		repeat (3000) @(posedge clk_i);
		chk("glitch dropped", rx_cnt - c, 0);
		get(A_ST, 32'h0C, "status glitch");
		put(A_C2, 8'h08);
		rx_frame(8'hC3, 1'b0, 2'b11, 1);
		get(A_ST, 32'h1C, "filtered frame");
		get(A_RX, 32'hC3, "rx data filtered");
		$display("test filter done");
	endtask
	// ----
	// clock, reset and sequence
	// ----
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
		if (rx_int === 1'b1)
			rx_cnt <= rx_cnt + 1;
	initial
	begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 16'h0000;
		sel_i = 4'hF;
		dat_i = 32'h00000000;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_unarmed();
		t_reset();
		t_tx(3'h0, 13, 8'h01, 1'b0, 1'b0, 1'b0, 8'hA5);
		t_tx(3'h1, 26, 8'h01, 1'b1, 1'b0, 1'b1, 8'h5E);
		t_tx(3'h7, 96, 8'h01, 1'b1, 1'b1, 1'b1, 8'h3D);
		t_tx(3'h6, 5, 8'h05, 1'b1, 1'b0, 1'b0, 8'h81);
		t_rx();
		t_filter();
		tally_and_finish();
	end
endmodule
